//--- verilog/idec_pkg.sv
// Opcode constants, decode classes and timing figures for the instruction decoder
package idec_pkg;

  // Clock and machine-cycle timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLKS_PER_MCYC = 2;
  localparam logic [2:0] MCYC_ONE = 3'h1;
  localparam logic [2:0] MCYC_TWO = 3'h2;
  localparam logic [2:0] MCYC_FOUR = 3'h4;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // Single opcodes
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_LJMP = 8'h02;
  localparam logic [7:0] OP_RR = 8'h03;
  localparam logic [7:0] OP_JBC = 8'h10;
  localparam logic [7:0] OP_LCALL = 8'h12;
  localparam logic [7:0] OP_RRC = 8'h13;
  localparam logic [7:0] OP_JB = 8'h20;
  localparam logic [7:0] OP_RET = 8'h22;
  localparam logic [7:0] OP_RL = 8'h23;
  localparam logic [7:0] OP_JNB = 8'h30;
  localparam logic [7:0] OP_RETI = 8'h32;
  localparam logic [7:0] OP_RLC = 8'h33;
  localparam logic [7:0] OP_JC = 8'h40;
  localparam logic [7:0] OP_JNC = 8'h50;
  localparam logic [7:0] OP_JZ = 8'h60;
  localparam logic [7:0] OP_JNZ = 8'h70;
  localparam logic [7:0] OP_ORL_C_BIT = 8'h72;
  localparam logic [7:0] OP_JMP_IND = 8'h73;
  localparam logic [7:0] OP_MOV_A_IMM = 8'h74;
  localparam logic [7:0] OP_MOV_D_IMM = 8'h75;
  localparam logic [7:0] OP_SJMP = 8'h80;
  localparam logic [7:0] OP_ANL_C_BIT = 8'h82;
  localparam logic [7:0] OP_CODE_PC = 8'h83;
  localparam logic [7:0] OP_DIV = 8'h84;
  localparam logic [7:0] OP_MOV_D_D = 8'h85;
  localparam logic [7:0] OP_LOAD_DP = 8'h90;
  localparam logic [7:0] OP_MOV_BIT_C = 8'h92;
  localparam logic [7:0] OP_CODE_DP = 8'h93;
  localparam logic [7:0] OP_ORL_C_NBIT = 8'hA0;
  localparam logic [7:0] OP_MOV_C_BIT = 8'hA2;
  localparam logic [7:0] OP_INC_DP = 8'hA3;
  localparam logic [7:0] OP_MUL = 8'hA4;
  localparam logic [7:0] OP_EXT = 8'hA5;
  localparam logic [7:0] OP_ANL_C_NBIT = 8'hB0;
  localparam logic [7:0] OP_CPL_BIT = 8'hB2;
  localparam logic [7:0] OP_CPL_C = 8'hB3;
  localparam logic [7:0] OP_CJNE_IMM = 8'hB4;
  localparam logic [7:0] OP_CJNE_DIR = 8'hB5;
  localparam logic [7:0] OP_PUSH = 8'hC0;
  localparam logic [7:0] OP_CLR_BIT = 8'hC2;
  localparam logic [7:0] OP_CLR_C = 8'hC3;
  localparam logic [7:0] OP_SWAP = 8'hC4;
  localparam logic [7:0] OP_POP = 8'hD0;
  localparam logic [7:0] OP_SET_BIT = 8'hD2;
  localparam logic [7:0] OP_SET_C = 8'hD3;
  localparam logic [7:0] OP_DAA = 8'hD4;
  localparam logic [7:0] OP_DJNZ_DIR = 8'hD5;
  localparam logic [7:0] OP_XRD_DP = 8'hE0;
  localparam logic [7:0] OP_CLR_A = 8'hE4;
  localparam logic [7:0] OP_XWR_DP = 8'hF0;
  localparam logic [7:0] OP_CPL_A = 8'hF4;

  // Absolute jump/call low five bits
  localparam logic [4:0] AJMP_LO5 = 5'h01;
  localparam logic [4:0] ACALL_LO5 = 5'h11;

  // Extended opcode select codes (upper nibble of the select field)
  localparam logic [3:0] EXT_SEL_STORE = 4'h0;

  // Operation classes driven to the datapath
  typedef enum logic [3:0] {
    OPC_NOP, OPC_ALU, OPC_UNARY, OPC_MULDIV, OPC_MOVE, OPC_CODE_RD, OPC_EXT_RD,
    OPC_EXT_WR, OPC_STACK, OPC_BIT, OPC_JUMP, OPC_CALL, OPC_RETURN, OPC_REL_BR,
    OPC_PSTORE, OPC_BREAK
  } op_class_t;

  typedef enum {ST_OPCODE, ST_OPERAND, ST_EXEC} dec_state_t;

endpackage

//--- verilog/cisc_instruction_decoder.sv
// Instruction fetch, length and machine-cycle timing decode for the 8-bit core
//
// Behaviour
// - Instruction length is one to three bytes
// - Execution takes one, two or four machine cycles
// - One machine cycle equals two clocks
// - Low opcode bits select bank or pointer register
// - Absolute jump/call: low five bits, address top
// - Add, addc, subb groups take one cycle
// - Inc/dec one cycle; data pointer inc two
// - Multiply and divide four cycles, adjust one
// - Logic immediate-to-direct three bytes, two cycles
// - Accumulator unary operations one byte, one cycle
// - Internal moves follow documented length and timing
// - Data pointer immediate load three bytes, two
// - Code reads use accumulator plus pointer or PC
// - External transfers use 8 or 16-bit address
// - Push/pop two cycles; exchanges one cycle
// - Carry and bit operations decode with timing
// - Long jump/call three bytes; branches two cycles
// - Relative branches decode; bit-clear form clears bit
// - Indirect jump targets accumulator plus data pointer
// - Compare-and-branch forms are three bytes
// - Decrement-and-branch register two, direct three bytes
// - Extended opcode: program store or software break
// - No-operation changes nothing, one byte, one cycle
`timescale 1ns/1ps
module cisc_instruction_decoder
  import idec_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Program memory fetch
  output logic [15:0] pmem_addr,
  output logic pmem_rd,
  input wire logic [7:0] pmem_data,
  input wire logic pmem_valid,
  // Extended opcode select field
  input wire logic [7:0] extended_opcode_select,
  // Decoded instruction to datapath, held through execution
  output logic [7:0] dec_opcode_q,
  output logic [7:0] dec_op1_q,
  output logic [7:0] dec_op2_q,
  output op_class_t dec_class_q,
  output logic [1:0] dec_len_q,
  output logic [2:0] dec_mcycles_q,
  output logic [2:0] bank_register_q,
  output logic indirect_pointer_register_q,
  output logic [15:0] abs_target_q,
  output logic [15:0] next_pc_q,
  output logic dec_clr_bit_q,
  output logic ext_addr16_q,
  output logic exec_valid,
  output logic instr_done
);

  // Length and cycle decode, shared by the fetch and latch paths
  function automatic logic [4:0] len_cyc(input logic [7:0] op, input logic [3:0] esel);
    logic [1:0] l;
    logic [2:0] c;
    l = LEN_ONE;
    c = MCYC_ONE;
    if (op[4:0] == AJMP_LO5 || op[4:0] == ACALL_LO5)
    begin
      l = LEN_TWO;
      c = MCYC_TWO;
    end
    else
    begin
      case (op)
        OP_NOP, OP_RR, OP_RRC, OP_RL, OP_RLC, OP_CLR_A, OP_CPL_A, OP_SWAP, OP_DAA,
        OP_CLR_C, OP_SET_C, OP_CPL_C:
          c = MCYC_ONE;
        OP_LJMP, OP_LCALL:
        begin
          l = LEN_THREE;
          c = MCYC_TWO;
        end
        OP_RET, OP_RETI, OP_JMP_IND, OP_INC_DP, OP_CODE_DP, OP_CODE_PC, OP_XRD_DP, OP_XWR_DP:
          c = MCYC_TWO;
        OP_MUL, OP_DIV:
          c = MCYC_FOUR;
        OP_SJMP, OP_JC, OP_JNC, OP_JZ, OP_JNZ, OP_PUSH, OP_POP, OP_ANL_C_BIT,
        OP_ANL_C_NBIT, OP_ORL_C_BIT, OP_ORL_C_NBIT, OP_MOV_BIT_C:
        begin
          l = LEN_TWO;
          c = MCYC_TWO;
        end
        OP_MOV_C_BIT, OP_CLR_BIT, OP_SET_BIT, OP_CPL_BIT, OP_MOV_A_IMM:
          l = LEN_TWO;
        OP_JB, OP_JNB, OP_JBC, OP_CJNE_IMM, OP_CJNE_DIR, OP_DJNZ_DIR, OP_MOV_D_D,
        OP_MOV_D_IMM, OP_LOAD_DP:
        begin
          l = LEN_THREE;
          c = MCYC_TWO;
        end
        OP_EXT:
          c = (esel == EXT_SEL_STORE) ? MCYC_TWO : MCYC_ONE;
        default:
        begin
          // Regular low-nibble forms: 2/3 imm, 4 imm, 5 dir, 6-7 @Ri, 8-F Rn
          case (op[7:4])
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'hC, 4'hD, 4'hE, 4'hF:
            begin
              // Arithmetic, logic, inc/dec, exchange, accumulator moves
              if (op[7:5] == 3'h7 && op[3:1] == 3'h1) c = MCYC_TWO; // Pointer I/O
              else if (op[7:5] == 3'h0 && op[3:0] == 4'h4) l = LEN_ONE; // No operand
              else if (op[3:0] == 4'h2) l = LEN_TWO;
              else if (op[3:0] == 4'h3) {l, c} = {LEN_THREE, MCYC_TWO};
              else if (op[3:0] == 4'h4 || op[3:0] == 4'h5) l = LEN_TWO;
              if (op[7:4] == 4'hD && op[3]) {l, c} = {LEN_TWO, MCYC_TWO};
            end
            4'hB:
              {l, c} = {LEN_THREE, MCYC_TWO};
            4'h7:
              l = LEN_TWO; // Immediate to register/indirect, one cycle
            4'h8, 4'hA:
              {l, c} = {LEN_TWO, MCYC_TWO};
            default:
              l = LEN_ONE;
          endcase
        end
      endcase
    end
    return {l, c};
  endfunction

  // Operation class decode
  function automatic op_class_t classify(input logic [7:0] op, input logic [3:0] esel);
    op_class_t k;
    k = OPC_ALU;
    if (op[4:0] == AJMP_LO5) k = OPC_JUMP;
    else if (op[4:0] == ACALL_LO5) k = OPC_CALL;
    else
    begin
      case (op)
        OP_NOP: k = OPC_NOP;
        OP_LJMP, OP_JMP_IND: k = OPC_JUMP;
        OP_LCALL: k = OPC_CALL;
        OP_RET, OP_RETI: k = OPC_RETURN;
        OP_RR, OP_RRC, OP_RL, OP_RLC, OP_CLR_A, OP_CPL_A, OP_SWAP, OP_DAA: k = OPC_UNARY;
        OP_MUL, OP_DIV: k = OPC_MULDIV;
        OP_CODE_DP, OP_CODE_PC: k = OPC_CODE_RD;
        OP_XRD_DP, 8'hE2, 8'hE3: k = OPC_EXT_RD;
        OP_XWR_DP, 8'hF2, 8'hF3: k = OPC_EXT_WR;
        OP_PUSH, OP_POP: k = OPC_STACK;
        OP_SJMP, OP_JC, OP_JNC, OP_JZ, OP_JNZ, OP_JB, OP_JNB, OP_JBC, OP_CJNE_IMM,
        OP_CJNE_DIR, OP_DJNZ_DIR: k = OPC_REL_BR;
        OP_ANL_C_BIT, OP_ANL_C_NBIT, OP_ORL_C_BIT, OP_ORL_C_NBIT, OP_MOV_BIT_C, OP_MOV_C_BIT,
        OP_CLR_BIT, OP_SET_BIT, OP_CPL_BIT, OP_CLR_C, OP_SET_C, OP_CPL_C: k = OPC_BIT;
        OP_EXT: k = (esel == EXT_SEL_STORE) ? OPC_PSTORE : OPC_BREAK;
        OP_MOV_D_D, OP_MOV_D_IMM, OP_LOAD_DP, OP_MOV_A_IMM: k = OPC_MOVE;
        default:
        begin
          if (op[7:4] == 4'hB || (op[7:4] == 4'hD && op[3])) k = OPC_REL_BR;
          else if (op[7:4] >= 4'h7 && op[7:4] != 4'h9) k = OPC_MOVE;
          else k = OPC_ALU;
        end
      endcase
    end
    return k;
  endfunction

  // Fetch and execution state
  dec_state_t state_q, state_d;
  logic [15:0] pc_q, pc_d;
  logic [1:0] got_q, got_d;
  logic [3:0] clk_cnt_q, clk_cnt_d;
  logic [7:0] op_q, op_d, op1_q, op1_d, op2_q, op2_d;
  logic [4:0] lc_now, lc_hold, lc_start;

  assign lc_now = len_cyc(pmem_data, extended_opcode_select[7:4]);
  assign lc_hold = len_cyc(op_q, extended_opcode_select[7:4]);
  assign lc_start = len_cyc(op_d, extended_opcode_select[7:4]);
  assign pmem_addr = pc_q;
  assign pmem_rd = (state_q != ST_EXEC);
  assign exec_valid = (state_q == ST_EXEC);
  assign instr_done = exec_valid && (clk_cnt_q == 4'h1);

  // Next-state: fetch bytes at consecutive addresses, then count 2 clocks per cycle
  always_comb
  begin
    state_d = state_q;
    pc_d = pc_q;
    got_d = got_q;
    clk_cnt_d = clk_cnt_q;
    op_d = op_q;
    op1_d = op1_q;
    op2_d = op2_q;
    case (state_q)
      ST_OPCODE:
        if (pmem_valid)
        begin
          op_d = pmem_data;
          pc_d = pc_q + 16'h0001;
          got_d = LEN_ONE;
          op1_d = 8'h00;
          op2_d = 8'h00;
          if (lc_now[4:3] == LEN_ONE)
          begin
            state_d = ST_EXEC;
            clk_cnt_d = 4'(lc_now[2:0] * CLKS_PER_MCYC);
          end
          else state_d = ST_OPERAND;
        end
      ST_OPERAND:
        if (pmem_valid)
        begin
          pc_d = pc_q + 16'h0001;
          got_d = got_q + 2'h1;
          if (got_q == LEN_ONE) op1_d = pmem_data;
          else op2_d = pmem_data;
          if (got_q + 2'h1 == lc_hold[4:3])
          begin
            state_d = ST_EXEC;
            clk_cnt_d = 4'(lc_hold[2:0] * CLKS_PER_MCYC);
          end
        end
      ST_EXEC:
      begin
        clk_cnt_d = clk_cnt_q - 4'h1;
        if (clk_cnt_q == 4'h1) state_d = ST_OPCODE;
      end
      default:
        state_d = ST_OPCODE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      state_q <= ST_OPCODE;
      pc_q <= 16'h0000;
      got_q <= 2'h0;
      clk_cnt_q <= 4'h0;
      op_q <= 8'h00;
      op1_q <= 8'h00;
      op2_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      pc_q <= pc_d;
      got_q <= got_d;
      clk_cnt_q <= clk_cnt_d;
      op_q <= op_d;
      op1_q <= op1_d;
      op2_q <= op2_d;
    end
  end

  // Decoded outputs registered when execution starts; held until done
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      dec_opcode_q <= 8'h00;
      dec_op1_q <= 8'h00;
      dec_op2_q <= 8'h00;
      dec_class_q <= OPC_NOP;
      dec_len_q <= 2'h0;
      dec_mcycles_q <= 3'h0;
      bank_register_q <= 3'h0;
      indirect_pointer_register_q <= 1'b0;
      abs_target_q <= 16'h0000;
      next_pc_q <= 16'h0000;
      dec_clr_bit_q <= 1'b0;
      ext_addr16_q <= 1'b0;
    end
    else if (state_q != ST_EXEC && state_d == ST_EXEC)
    begin
      dec_opcode_q <= op_d;
      dec_op1_q <= op1_d;
      dec_op2_q <= op2_d;
      dec_class_q <= classify(op_d, extended_opcode_select[7:4]);
      dec_len_q <= lc_start[4:3];
      dec_mcycles_q <= lc_start[2:0];
      bank_register_q <= op_d[2:0];
      indirect_pointer_register_q <= op_d[0];
      // Absolute target within the page of the following instruction
      abs_target_q <= {pc_d[15:11], op_d[7:5], op1_d};
      next_pc_q <= pc_d;
      dec_clr_bit_q <= (op_d == OP_JBC);
      ext_addr16_q <= (op_d == OP_XRD_DP || op_d == OP_XWR_DP);
    end
  end

  // Execution length ties to the decoded cycle count
  property p_exec_len;
    @(posedge mclk) disable iff (!rstn)
    $rose(exec_valid) |-> (clk_cnt_q == 4'(dec_mcycles_q * CLKS_PER_MCYC));
  endproperty
  a_exec_len: assert property (p_exec_len) else $error("bad exec length");
  property p_mul_four;
    @(posedge mclk) disable iff (!rstn)
    ($rose(exec_valid) && dec_opcode_q == OP_MUL) |-> exec_valid [*8] ##1 !exec_valid;
  endproperty
  a_mul_four: assert property (p_mul_four) else $error("multiply not 8 clocks");
  property p_nop_one;
    @(posedge mclk) disable iff (!rstn)
    ($rose(exec_valid) && dec_opcode_q == OP_NOP) |-> ##1 instr_done ##1 !exec_valid;
  endproperty
  a_nop_one: assert property (p_nop_one) else $error("nop not 2 clocks");
  property p_ljmp_len;
    @(posedge mclk) disable iff (!rstn)
    ($rose(exec_valid) && dec_opcode_q == OP_LJMP) |-> dec_len_q == LEN_THREE
      && next_pc_q == pmem_addr && dec_mcycles_q == MCYC_TWO;
  endproperty
  a_ljmp_len: assert property (p_ljmp_len) else $error("long jump decode");
  property p_bank;
    @(posedge mclk) disable iff (!rstn)
    $rose(exec_valid) |-> bank_register_q == dec_opcode_q[2:0];
  endproperty
  a_bank: assert property (p_bank) else $error("bank select wrong");
  property p_pc_adv;
    @(posedge mclk) disable iff (!rstn)
    (pmem_rd && pmem_valid) |=> pmem_addr == $past(pmem_addr) + 16'h0001;
  endproperty
  a_pc_adv: assert property (p_pc_adv) else $error("pc not advanced");
  property p_abs;
    @(posedge mclk) disable iff (!rstn)
    ($rose(exec_valid) && dec_opcode_q[4:0] == AJMP_LO5) |->
      abs_target_q[10:8] == dec_opcode_q[7:5] && dec_len_q == LEN_TWO;
  endproperty
  a_abs: assert property (p_abs) else $error("absolute target wrong");
  property p_anl_imm;
    @(posedge mclk) disable iff (!rstn)
    ($rose(exec_valid) && dec_opcode_q == 8'h53) |-> dec_len_q == LEN_THREE
      && dec_mcycles_q == MCYC_TWO;
  endproperty
  a_anl_imm: assert property (p_anl_imm) else $error("logic imm direct wrong");

endmodule

//--- testbench/prog_mem_model.sv
// Program memory model that offers opcode and operand bytes to the decoder
`timescale 1ns/1ps
module prog_mem_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Fetch port
  input wire logic [15:0] pmem_addr,
  input wire logic pmem_rd,
  output logic [7:0] pmem_data,
  output logic pmem_valid,
  // Bench control, withholds the byte to model a slow memory
  input wire logic stall
);
  logic [7:0] mem [0:65535];
  logic valid_q;
  logic [7:0] junk_q;
  integer seed;
  integer i;

  // Random contents so every opcode shows up somewhere along the path
  initial
  begin
    seed = 32'h6787;
    for (i = 0; i < 65536; i++)
      mem[i] = 8'($random(seed));
  end

  // A byte once offered stays offered until the decoder takes it
  always @(posedge mclk)
  begin
    // Seeded in reset so the filler pattern is never unknown
    junk_q <= rstn ? junk_q + 8'h5B : 8'hC3;
    if (!rstn)
      valid_q <= 1'b0;
    else if (valid_q && !pmem_rd)
      valid_q <= 1'b1;
    else
      valid_q <= !stall;
  end

  // Unoffered data changes every cycle so a stale read never looks right
  assign pmem_valid = valid_q;
  assign pmem_data = valid_q ? mem[pmem_addr] : junk_q;
endmodule

//--- testbench/test_cisc_instruction_decoder.sv
// Self-checking bench comparing decode and timing with a table-driven model
`timescale 1ns/1ps
module test_cisc_instruction_decoder;
  import idec_pkg::*;
  logic mclk, rstn, stall, slow, pmem_rd, pmem_valid, ipr, clr_bit, addr16, exec_valid, done;
  logic [15:0] pmem_addr, abs_target, next_pc;
  logic [7:0] pmem_data, ext_sel, opc, op1, op2, ext_at, rnd;
  logic [2:0] bank, mcyc;
  logic [1:0] len;
  op_class_t cls;
  logic [15:0] fa [$];
  logic [7:0] fd [$];
  bit seen [0:255];
  bit hung;
  int errors, samples_checked, ecnt, ninstr, nseen, k;
  logic prev_exec, prev_done;
  integer seed;

  // Design and memory
  cisc_instruction_decoder DUT (.mclk(mclk), .rstn(rstn), .pmem_addr(pmem_addr),
    .pmem_rd(pmem_rd), .pmem_data(pmem_data), .pmem_valid(pmem_valid),
    .extended_opcode_select(ext_sel), .dec_opcode_q(opc), .dec_op1_q(op1), .dec_op2_q(op2),
    .dec_class_q(cls), .dec_len_q(len), .dec_mcycles_q(mcyc), .bank_register_q(bank),
    .indirect_pointer_register_q(ipr), .abs_target_q(abs_target), .next_pc_q(next_pc),
    .dec_clr_bit_q(clr_bit), .ext_addr16_q(addr16), .exec_valid(exec_valid), .instr_done(done));
  prog_mem_model PMEM (.mclk(mclk), .rstn(rstn), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
    .pmem_data(pmem_data), .pmem_valid(pmem_valid), .stall(stall));

  always #2.5 mclk = ~mclk;

  // Reference length in bytes
  function automatic int ref_len(input logic [7:0] op);
    if (op[4:0] == 5'h01 || op[4:0] == 5'h11) return 2;
    case (op)
      8'h02, 8'h12, 8'h53, 8'h43, 8'h63, 8'h85, 8'h75, 8'h90, 8'hB4, 8'hB5, 8'h10, 8'h20,
      8'h30, 8'hD5: return 3;
      8'h00, 8'h03, 8'h13, 8'h23, 8'h33, 8'h04, 8'h14, 8'h22, 8'h32, 8'h73, 8'h83, 8'h93,
      8'hA3, 8'hA4, 8'h84, 8'hD4, 8'hE4, 8'hF4, 8'hC4, 8'hC3, 8'hD3, 8'hB3, 8'hE0, 8'hF0,
      8'hE2, 8'hE3, 8'hF2, 8'hF3, 8'hA5: return 1;
      default: ;
    endcase
    if (op[3] || op[3:1] == 3'h3)
    begin
      if (op[7:4] == 4'hB) return 3;
      if (op[7:4] == 4'h7 || op[7:4] == 4'h8 || op[7:4] == 4'hA) return 2;
      return (op[7:4] == 4'hD && op[3]) ? 2 : 1;
    end
    return 2;
  endfunction

  // Reference execution time in machine cycles
  function automatic int ref_cyc(input logic [7:0] op, input logic [7:0] ext);
    if (op == 8'hA4 || op == 8'h84) return 4;
    if (op == 8'hA5) return (ext[7:4] == 4'h0) ? 2 : 1;
    if ((op[3:0] == 4'h0 && op != 8'h00) || op[4:0] == 5'h01 || op[4:0] == 5'h11) return 2;
    case (op)
      8'h02, 8'h12, 8'h22, 8'h32, 8'h53, 8'h43, 8'h63, 8'h85, 8'h75, 8'hA3, 8'h93, 8'h83,
      8'hE2, 8'hE3, 8'hF2, 8'hF3, 8'h82, 8'h72, 8'h92, 8'h73, 8'hB4, 8'hB5,
      8'hD5: return 2;
      default: ;
    endcase
    if ((op[7:4] == 4'hA || op[7:4] == 4'h8) && (op[3] || op[3:1] == 3'h3)) return 2;
    if ((op[7:4] == 4'hB && op[3:0] >= 4'h6) || (op[7:4] == 4'hD && op[3])) return 2;
    return 1;
  endfunction

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("Counts: %0d comparisons, %0d mismatches", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Compare decoded outputs with the bytes actually taken
  task automatic check_decode();
    logic [7:0] op, b1, b2;
    logic [15:0] npc;
    int n;
    op = fd[0];
    n = ref_len(op);
    npc = fa[0] + 16'(n);
    b1 = (n > 1 && fd.size() > 1) ? fd[1] : 8'h00;
    b2 = (n > 2 && fd.size() > 2) ? fd[2] : 8'h00;
    seen[op] = 1'b1;
    check("byte_count", n, fd.size());
    for (int j = 1; j < fd.size(); j++)
      check("operand_addr", fa[0] + 16'(j), fa[j]);
    check("opcode", op, opc);
    check("op1", b1, op1);
    check("op2", b2, op2);
    check("length", n, len);
    check("mcycles", ref_cyc(op, ext_at), mcyc);
    check("bank_register", op[2:0], bank);
    check("pointer_register", op[0], ipr);
    if (op[4:0] == 5'h01 || op[4:0] == 5'h11)
      check("abs_target", {npc[15:11], op[7:5], b1}, abs_target);
    check("next_pc", npc, next_pc);
    check("clear_bit", op == 8'h10, clr_bit);
    check("addr16", op == 8'hE0 || op == 8'hF0, addr16);
    if (op == 8'hA5)
      check("ext_class", (ext_at[7:4] == 4'h0) ? OPC_PSTORE : OPC_BREAK, cls);
    if (op == 8'h00)
      check("nop_class", OPC_NOP, cls);
  endtask

  // Stimulus first, then the monitor: between edges every value equals what the
  // next rising edge takes, so sampling here never races the design's registers
  always @(negedge mclk)
  begin
    stall = slow ? 1'($random(seed)) : 1'b0;
    // Select field only moves during execution, over half the time with a zero top nibble
    if (exec_valid)
    begin
      rnd = 8'($random(seed));
      ext_sel = rnd[0] ? {4'h0, rnd[3:0]} : rnd;
    end
    if (!rstn)
    begin
      fa.delete();
      fd.delete();
      ecnt = 0;
      prev_exec = 0;
      prev_done = 0;
    end
    else
    begin
      if (prev_done)
      begin
        check("fetch_after_done", 1, pmem_rd);
        check("exec_after_done", 0, exec_valid);
      end
      if (pmem_rd && pmem_valid)
      begin
        if (fa.size() == 0)
          ext_at = ext_sel;
        fa.push_back(pmem_addr);
        fd.push_back(pmem_data);
      end
      if (exec_valid === 1'b1 && fd.size() > 0)
      begin
        check("rd_in_exec", 0, pmem_rd);
        if (!prev_exec)
          check_decode();
        ecnt++;
      end
      if (done === 1'b1 && fd.size() > 0)
      begin
        check("exec_clocks", 2 * ref_cyc(fd[0], ext_at), ecnt);
        ecnt = 0;
        fa.delete();
        fd.delete();
        ninstr++;
      end
      prev_exec = exec_valid;
      prev_done = done;
    end
  end

  task automatic run_phase(input string name, input int target);
    int lim, start;
    lim = 0;
    start = ninstr;
    // A hang skips the remaining phases and falls through to the verdict
    while (!hung && ninstr < start + target && lim < target * 20)
    begin
      @(negedge mclk);
      lim++;
    end
    if (lim >= target * 20)
    begin
      hung = 1'b1;
      errors++;
      $display("CHECK FAILED progress expected %0d seen %0d", target, ninstr - start);
    end
    $display("Test %s done: %0d instructions", name, ninstr - start);
  endtask

  task automatic apply_reset(input int n);
    @(negedge mclk);
    rstn = 1'b0;
    repeat (n) @(negedge mclk);
    check("reset_addr", 16'h0000, pmem_addr);
    check("reset_rd", 1, pmem_rd);
    check("reset_exec", 0, exec_valid);
    rstn = 1'b1;
  endtask

  initial
  begin
    mclk = 0;
    rstn = 0;
    slow = 0;
    stall = 0;
    ext_sel = 8'h00;
    seed = 32'h6787;
    errors = 0;
    samples_checked = 0;
    ninstr = 0;
    apply_reset(3);
    run_phase("prompt_memory", 3000);
    slow = 1;
    run_phase("slow_memory", 1000);
    repeat (3) @(negedge mclk);
    apply_reset(2);
    slow = 0;
    run_phase("after_midrun_reset", 500);
    nseen = 0;
    for (k = 0; k < 256; k++)
      nseen += seen[k];
    check("opcodes_covered", 256, nseen);
    $display("Test coverage done: %0d opcodes decoded", nseen);
    give_verdict();
  end
endmodule
